// file: shared/rft_params.svh
// Constants for the register file transfer unit
`ifndef RFT_PARAMS_SVH
`define RFT_PARAMS_SVH
// ----------------------------------------
// APB register offsets
// ----------------------------------------
`define RFT_OFF_CTRL    12'h000
`define RFT_OFF_PSR     12'h004
`define RFT_OFF_PRED_LO 12'h008
`define RFT_OFF_PRED_HI 12'h00c
`define RFT_OFF_OPCNT   12'h010
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define RFT_CTRL_PMD_EN 0
`define RFT_UM_MSB      5
`define RFT_PR_ROT_LSB  16
`define RFT_PMASK_ROT   16
`define RFT_PSR_RST     32'h0000_0000
`define RFT_CTRL_RST    1'b0
// ----------------------------------------
// Floating-point register format
// ----------------------------------------
`define RFT_INT_EXP     17'h1003e
`define RFT_FR_BIAS     17'h0ffff
`define RFT_EXP_ONES    17'h1ffff
`define RFT_SGL_BIAS    17'h0007f
`define RFT_DBL_BIAS    17'h003ff
`define RFT_SGL_EMAX    17'h000ff
`define RFT_DBL_EMAX    17'h007ff
`define RFT_SIG_INT     64'h8000_0000_0000_0000
`define RFT_NATVAL_EXP  17'h1fffe
`endif

// file: shared/rft_pkg.sv
// Types for the register file transfer unit
package rft_pkg;
   // Transfer operation from decode
   typedef enum logic [3:0] {
      OP_NONE     = 4'h0,
      OP_GETF_SIG = 4'h1,
      OP_GETF_EXP = 4'h2,
      OP_GETF_S   = 4'h3,
      OP_GETF_D   = 4'h4,
      OP_SETF_SIG = 4'h5,
      OP_SETF_EXP = 4'h6,
      OP_SETF_S   = 4'h7,
      OP_SETF_D   = 4'h8,
      OP_MOV_TO_GR   = 4'h9,
      OP_MOV_FROM_GR = 4'ha,
      OP_PR_MASK  = 4'hb,
      OP_PR_ROT   = 4'hc,
      OP_UM_SET   = 4'hd,
      OP_UM_CLR   = 4'he
   } rft_op_t;
   // Operand kind that selects the other file of a move
   typedef enum logic [2:0] {
      KIND_BR    = 3'h0,
      KIND_PR    = 3'h1,
      KIND_AR    = 3'h2,
      KIND_UM    = 3'h3,
      KIND_PMD   = 3'h4,
      KIND_CPUID = 3'h5,
      KIND_IP    = 3'h6
   } rft_kind_t;
   // Request from the execute pipeline
   typedef struct packed {
      logic        valid;
      rft_op_t     op;
      rft_kind_t   kind;
      logic [6:0]  idx;
      logic [63:0] gr_val;
      logic        gr_nat;
      logic [81:0] fr_val;
      logic [23:0] imm;
      logic [2:0]  hint;
   } rft_req_t;
   // Result back to the pipeline
   typedef struct packed {
      logic        valid;
      logic        gr_we;
      logic [63:0] gr_val;
      logic        gr_nat;
      logic        fr_we;
      logic [81:0] fr_val;
      logic        hint_vld;
      logic [2:0]  hint;
      logic        fault;
   } rft_rsp_t;
endpackage : rft_pkg

// file: hdl/rft_fp_xlat.sv
// General/floating-point register format translation
`timescale 1ns/10ps
`default_nettype none
`include "rft_params.svh"

module rft_fp_xlat (
   input  wire rft_pkg::rft_op_t op,
   input  wire logic [63:0]      gr_val,
   input  wire logic             gr_nat,
   input  wire logic [81:0]      fr_val,
   output logic [63:0]           gr_out,
   output logic                  gr_nat_out,
   output logic [81:0]           fr_out
);
   import rft_pkg::*;

   localparam logic [81:0] NATVAL = {1'b0, `RFT_NATVAL_EXP, 64'h0};

   logic        sgn;
   logic [16:0] exp;
   logic [63:0] sig;
   logic [16:0] re_s;
   logic [16:0] re_d;

   assign {sgn, exp, sig} = fr_val;
   assign re_s = exp - (`RFT_FR_BIAS - `RFT_SGL_BIAS);
   assign re_d = exp - (`RFT_FR_BIAS - `RFT_DBL_BIAS);

   // Memory format to register format, fraction left aligned
   function automatic logic [81:0] mem_to_fr(input logic s, input logic [16:0] e,
         input logic [16:0] emax, input logic [16:0] bias, input logic [62:0] f);
      logic [16:0] eb;
      eb = e + (`RFT_FR_BIAS - bias);
      if (e == 17'h0 && f == 63'h0) mem_to_fr = {s, 17'h0, 64'h0};
      else if (e == emax) mem_to_fr = {s, `RFT_EXP_ONES, 1'b1, f};
      else if (e == 17'h0) mem_to_fr = {s, `RFT_FR_BIAS - bias + 17'h1, 1'b0, f};
      else mem_to_fr = {s, eb, 1'b1, f};
   endfunction : mem_to_fr

   // Register to general direction, token maps to NaT
   always_comb begin
      gr_out     = 64'h0;
      gr_nat_out = 1'b0;
      if (fr_val == NATVAL) begin
         gr_nat_out = 1'b1;
      end else begin
         case (op)
            OP_GETF_SIG: gr_out = sig;
            OP_GETF_EXP: gr_out = {46'h0, sgn, exp};
            OP_GETF_S: begin
               if (exp == `RFT_EXP_ONES) gr_out = {32'h0, sgn, 8'hff, sig[62:40]};
               else if (sig == 64'h0) gr_out = {32'h0, sgn, 31'h0};
               else gr_out = {32'h0, sgn, re_s[7:0], sig[62:40]};
            end
            OP_GETF_D: begin
               if (exp == `RFT_EXP_ONES) gr_out = {sgn, 11'h7ff, sig[62:11]};
               else if (sig == 64'h0) gr_out = {sgn, 63'h0};
               else gr_out = {sgn, re_d[10:0], sig[62:11]};
            end
            default: gr_out = 64'h0;
         endcase
      end
   end

   // General to register direction, NaT maps to token
   always_comb begin
      fr_out = NATVAL;
      if (!gr_nat) begin
         case (op)
            OP_SETF_SIG: fr_out = {1'b0, `RFT_INT_EXP, gr_val};
            OP_SETF_EXP: fr_out = {gr_val[17], gr_val[16:0], `RFT_SIG_INT};
            OP_SETF_S: fr_out = mem_to_fr(gr_val[31], {9'h0, gr_val[30:23]},
                  `RFT_SGL_EMAX, `RFT_SGL_BIAS, {gr_val[22:0], 40'h0});
            OP_SETF_D: fr_out = mem_to_fr(gr_val[63], {6'h0, gr_val[62:52]},
                  `RFT_DBL_EMAX, `RFT_DBL_BIAS, {gr_val[51:0], 11'h0});
            default: fr_out = NATVAL;
         endcase
      end
   end
endmodule : rft_fp_xlat
`default_nettype wire

// file: hdl/rft_top.sv
// Register file transfer unit with APB control registers
//
// Contract
// - One move op picks the other file from the operand kind field.
// - Only general and float files face memory; others go through general.
// - Copy significand or sign plus exponent between general and float, both ways.
// - Move single/double memory numbers both ways, translating NaT tokens.
// - Copy branch to general and general to branch, with optional hints.
// - Predicate N maps to general bit N in both directions.
// - Mask holds bits for predicates 1..15 plus one bit for 16..63.
// - Predicate 0 always reads one; writes to it are dropped.
// - Masked write: set bits take general bit, clear bits keep value.
// - Rotating predicates move as if rename base were zero; base untouched.
// - Predicate read returns the whole file in one general result.
// - Read and write user mask, plus immediate set and clear of bits.
// - User mask is the low part of the status register itself.
// - Performance data reads return zero unless user reading is enabled.
// - Indexed identification register copies into a general result.
// - Current instruction pointer copies into a general result.
// - Float values are 82 bits: sign, 17-bit exponent, 64-bit significand.
// - Integer into significand gets exponent 0x1003E and sign zero.
`timescale 1ns/10ps
`default_nettype none
`include "rft_params.svh"

module rft_top #(
   parameter int NUM_BR    = 8,
   parameter int NUM_AR    = 8,
   parameter int NUM_PMD   = 4,
   parameter int NUM_CPUID = 5,
   // Identification words, values arbitrary
   parameter logic [NUM_CPUID*64-1:0] CPUID_VAL = '0
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire rft_pkg::rft_req_t        req,
   input  wire logic [63:0]              instr_ptr,
   input  wire logic [NUM_PMD*64-1:0]    pmd_value,
   output rft_pkg::rft_rsp_t             rsp
);
   import rft_pkg::*;

   localparam int BW = (NUM_BR > 1) ? $clog2(NUM_BR) : 1;
   localparam int AW = (NUM_AR > 1) ? $clog2(NUM_AR) : 1;
   localparam int PW = (NUM_PMD > 1) ? $clog2(NUM_PMD) : 1;
   localparam int CW = (NUM_CPUID > 1) ? $clog2(NUM_CPUID) : 1;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [63:1] pr_q, pr_d;
   logic [63:0] br_q [NUM_BR];
   logic [63:0] br_d [NUM_BR];
   logic [63:0] ar_q [NUM_AR];
   logic [63:0] ar_d [NUM_AR];
   logic [31:0] psr_q, psr_d;
   logic        pmd_en_q, pmd_en_d;
   logic [31:0] opcnt_q, opcnt_d;
   logic [31:0] prdata_q, prdata_d;
   logic        perr_q, perr_d;
   rft_rsp_t    rsp_q, rsp_d;

   logic [63:0] pr_file;
   logic [63:0] pr_mask;
   logic [63:0] pmd_w [NUM_PMD];
   logic [63:0] cpuid_w [NUM_CPUID];
   logic [63:0] x_gr;
   logic        x_nat;
   logic [81:0] x_fr;
   logic        apb_wr;
   logic        br_ok, ar_ok, pmd_ok, cpu_ok;

   assign pr_file = {pr_q, 1'b1};
   assign apb_wr  = psel && penable && pwrite && !perr_q;
   assign br_ok   = req.idx < 7'(NUM_BR);
   assign ar_ok   = req.idx < 7'(NUM_AR);
   assign pmd_ok  = req.idx < 7'(NUM_PMD);
   assign cpu_ok  = req.idx < 7'(NUM_CPUID);

   // ----------------------------------------
   // Per entry unpacking and write mask
   // ----------------------------------------
   for (genvar g = 0; g < 64; g++) begin : g_mask
      if (g == 0) begin : g_p0
         assign pr_mask[g] = 1'b0;
      end else if (g < `RFT_PR_ROT_LSB) begin : g_stat
         assign pr_mask[g] = req.imm[g];
      end else begin : g_rot
         assign pr_mask[g] = req.imm[`RFT_PMASK_ROT];
      end
      if (g < NUM_PMD) begin : g_pmd
         assign pmd_w[g] = pmd_value[g*64 +: 64];
      end
      if (g < NUM_CPUID) begin : g_cpu
         assign cpuid_w[g] = CPUID_VAL[g*64 +: 64];
      end
   end

   // Format translation for float moves
   rft_fp_xlat u_xlat (
      .op         (req.op),
      .gr_val     (req.gr_val),
      .gr_nat     (req.gr_nat),
      .fr_val     (req.fr_val),
      .gr_out     (x_gr),
      .gr_nat_out (x_nat),
      .fr_out     (x_fr)
   );

   // ----------------------------------------
   // Transfer datapath
   // ----------------------------------------
   // Next values of the files, status word and result
   always_comb begin
      pr_d    = pr_q;
      br_d    = br_q;
      ar_d    = ar_q;
      psr_d   = psr_q;
      opcnt_d = opcnt_q;
      rsp_d   = '0;
      if (apb_wr && paddr == `RFT_OFF_PSR) psr_d = pwdata;
      if (req.valid) begin
         opcnt_d     = opcnt_q + 32'h1;
         rsp_d.valid = 1'b1;
         case (req.op)
            OP_GETF_SIG, OP_GETF_EXP, OP_GETF_S, OP_GETF_D: begin
               rsp_d.gr_we  = 1'b1;
               rsp_d.gr_val = x_gr;
               rsp_d.gr_nat = x_nat;
            end
            OP_SETF_SIG, OP_SETF_EXP, OP_SETF_S, OP_SETF_D: begin
               rsp_d.fr_we  = 1'b1;
               rsp_d.fr_val = x_fr;
            end
            OP_MOV_TO_GR: begin
               // Result goes to a general register; that is the path to memory
               rsp_d.gr_we = 1'b1;
               case (req.kind)
                  KIND_BR: rsp_d.gr_val = br_ok ? br_q[req.idx[BW-1:0]] : 64'h0;
                  KIND_PR: rsp_d.gr_val = pr_file;
                  KIND_AR: rsp_d.gr_val = ar_ok ? ar_q[req.idx[AW-1:0]] : 64'h0;
                  KIND_UM: rsp_d.gr_val = {58'h0, psr_q[`RFT_UM_MSB:0]};
                  KIND_PMD: rsp_d.gr_val = (pmd_en_q && pmd_ok) ?
                        pmd_w[req.idx[PW-1:0]] : 64'h0;
                  KIND_CPUID: rsp_d.gr_val = cpu_ok ?
                        cpuid_w[req.idx[CW-1:0]] : 64'h0;
                  KIND_IP: rsp_d.gr_val = instr_ptr;
                  default: rsp_d.fault = 1'b1;
               endcase
            end
            OP_MOV_FROM_GR: begin
               if (req.gr_nat) begin
                  rsp_d.fault = 1'b1;
               end else begin
                  case (req.kind)
                     KIND_BR: begin
                        if (br_ok) br_d[req.idx[BW-1:0]] = req.gr_val;
                        rsp_d.hint_vld = br_ok;
                        rsp_d.hint     = req.hint;
                        rsp_d.fault    = !br_ok;
                     end
                     KIND_AR: begin
                        if (ar_ok) ar_d[req.idx[AW-1:0]] = req.gr_val;
                        rsp_d.fault = !ar_ok;
                     end
                     KIND_UM: begin
                        psr_d[`RFT_UM_MSB:0] = req.gr_val[`RFT_UM_MSB:0];
                     end
                     default: rsp_d.fault = 1'b1;
                  endcase
               end
            end
            OP_PR_MASK: begin
               // Physical index equals logical: rename base never applied
               if (req.gr_nat) rsp_d.fault = 1'b1;
               else pr_d = (pr_q & ~pr_mask[63:1])
                     | (req.gr_val[63:1] & pr_mask[63:1]);
            end
            OP_PR_ROT: begin
               if (req.gr_nat) rsp_d.fault = 1'b1;
               else pr_d[63:`RFT_PR_ROT_LSB] = req.gr_val[63:`RFT_PR_ROT_LSB];
            end
            OP_UM_SET: begin
               psr_d[`RFT_UM_MSB:0] = psr_d[`RFT_UM_MSB:0] | req.imm[`RFT_UM_MSB:0];
            end
            OP_UM_CLR: begin
               psr_d[`RFT_UM_MSB:0] = psr_d[`RFT_UM_MSB:0] & ~req.imm[`RFT_UM_MSB:0];
            end
            default: rsp_d.fault = 1'b1;
         endcase
      end
   end

   // Register files and result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pr_q    <= '0;
         psr_q   <= `RFT_PSR_RST;
         opcnt_q <= 32'h0;
         rsp_q   <= '0;
         for (int i = 0; i < NUM_BR; i++) br_q[i] <= 64'h0;
         for (int i = 0; i < NUM_AR; i++) ar_q[i] <= 64'h0;
      end else begin
         pr_q    <= pr_d;
         psr_q   <= psr_d;
         opcnt_q <= opcnt_d;
         rsp_q   <= rsp_d;
         br_q    <= br_d;
         ar_q    <= ar_d;
      end
   end

   assign rsp = rsp_q;

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // Read data captured in setup, error for unmapped offsets
   always_comb begin
      prdata_d = prdata_q;
      perr_d   = perr_q;
      pmd_en_d = pmd_en_q;
      if (psel && !penable) begin
         perr_d = 1'b0;
         if (paddr == `RFT_OFF_CTRL) prdata_d = {31'h0, pmd_en_q};
         else if (paddr == `RFT_OFF_PSR) prdata_d = psr_q;
         else if (paddr == `RFT_OFF_PRED_LO) prdata_d = pr_file[31:0];
         else if (paddr == `RFT_OFF_PRED_HI) prdata_d = pr_file[63:32];
         else if (paddr == `RFT_OFF_OPCNT) prdata_d = opcnt_q;
         else begin
            prdata_d = 32'h0;
            perr_d   = 1'b1;
         end
      end
      if (apb_wr && paddr == `RFT_OFF_CTRL) pmd_en_d = pwdata[`RFT_CTRL_PMD_EN];
   end

   // Bus registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         perr_q   <= 1'b0;
         pmd_en_q <= `RFT_CTRL_RST;
      end else begin
         prdata_q <= prdata_d;
         perr_q   <= perr_d;
         pmd_en_q <= pmd_en_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && perr_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Write to the top branch entry, then a read of the same entry
   sequence s_br_wr;
      req.valid && req.op == OP_MOV_FROM_GR && req.kind == KIND_BR
         && req.idx == 7'h7 && !req.gr_nat;
   endsequence
   sequence s_br_rd;
      req.valid && req.op == OP_MOV_TO_GR && req.kind == KIND_BR && req.idx == 7'h7;
   endsequence

   property p_br_trip;
      s_br_wr |=> br_q[7] == $past(req.gr_val);
   endproperty
   a_br_trip: assert property (p_br_trip) else $error("branch value lost");

   property p_br_read;
      s_br_rd |=> rsp_q.gr_val == $past(br_q[7]);
   endproperty
   a_br_read: assert property (p_br_read) else $error("branch read wrong");

   property p_pr0_one;
      req.valid && req.op == OP_MOV_TO_GR && req.kind == KIND_PR |=> rsp_q.gr_val[0] && rsp_q.gr_we;
   endproperty
   a_pr0_one: assert property (p_pr0_one) else $error("predicate 0 not one");

   property p_mask_keep;
      req.valid && req.op == OP_PR_MASK && !req.imm[5] |=> pr_q[5] == $past(pr_q[5]);
   endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("unmasked predicate changed");

   property p_mask_take;
      req.valid && req.op == OP_PR_MASK && req.imm[`RFT_PMASK_ROT] && !req.gr_nat
         |=> pr_q[40] == $past(req.gr_val[40]);
   endproperty
   a_mask_take: assert property (p_mask_take) else $error("rotating bit not taken");

   property p_rot_take;
      req.valid && req.op == OP_PR_ROT && !req.gr_nat
         |=> pr_q[63:16] == $past(req.gr_val[63:16]) && pr_q[15:1] == $past(pr_q[15:1]);
   endproperty
   a_rot_take: assert property (p_rot_take) else $error("rotating write wrong");

   property p_pmd_zero;
      req.valid && req.op == OP_MOV_TO_GR && req.kind == KIND_PMD && !pmd_en_q
         |=> rsp_q.gr_val == 64'h0;
   endproperty
   a_pmd_zero: assert property (p_pmd_zero) else $error("perf data leaked");

   property p_setf_sig;
      req.valid && req.op == OP_SETF_SIG && !req.gr_nat
         |=> rsp_q.fr_val == {1'b0, `RFT_INT_EXP, $past(req.gr_val)};
   endproperty
   a_setf_sig: assert property (p_setf_sig) else $error("integer encoding wrong");

   property p_um_set;
      req.valid && req.op == OP_UM_SET && !(apb_wr && paddr == `RFT_OFF_PSR)
         |=> psr_q[5:0] == ($past(psr_q[5:0]) | $past(req.imm[5:0]));
   endproperty
   a_um_set: assert property (p_um_set) else $error("user mask set wrong");

   property p_ip;
      req.valid && req.op == OP_MOV_TO_GR && req.kind == KIND_IP
         |=> rsp_q.gr_val == $past(instr_ptr);
   endproperty
   a_ip: assert property (p_ip) else $error("instruction pointer wrong");
endmodule : rft_top
`default_nettype wire

// file: sim/rft_pipe_model.sv
// Pipeline-side model that issues transfer requests
`timescale 1ns/10ps
`default_nettype none
module rft_pipe_model (
   input  wire logic              pclk,
   output rft_pkg::rft_req_t      req,
   input  wire rft_pkg::rft_rsp_t rsp
);
   import rft_pkg::*;
   rft_rsp_t seen;
   initial begin
      req = '0;
   end
   // One request for one cycle, answer taken one edge later
   task automatic issue(input rft_op_t op, input rft_kind_t kind, input logic [6:0] idx,
                        input logic [63:0] gv, input logic nat, input logic [81:0] fv,
                        input logic [23:0] imm, input logic [2:0] hint);
      @(posedge pclk);
      req <= '{1'b1, op, kind, idx, gv, nat, fv, imm, hint};
      @(posedge pclk);
      req.valid <= 1'b0;
      // Operands lose meaning once valid drops
      req.gr_val <= ~gv;
      req.fr_val <= ~fv;
      // Answer stands in the cycle after the request edge
      @(posedge pclk);
      seen = rsp;
   endtask : issue
endmodule : rft_pipe_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the register file transfer unit
`timescale 1ns/10ps
`default_nettype none
`include "rft_params.svh"
module tb_top;
   import rft_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic        pready, pslverr, e;
   logic [63:0] ip = 64'h4000_0000_1230;
   rft_req_t    req;
   rft_rsp_t    rsp, r;
   rft_kind_t   k;
   rft_kind_t   rk [5] = '{KIND_PR, KIND_PMD, KIND_CPUID, KIND_IP, KIND_BR};
   int          failures = 0, checks_done = 0, nops = 0, cyc = 0;
   localparam logic [81:0] ONE = {1'b0, 17'h0ffff, `RFT_SIG_INT};
   rft_top #(.CPUID_VAL({64'h5, 64'h4, 64'h3, 64'h2, 64'h1})) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req(req), .instr_ptr(ip), .pmd_value({64'h4444, 64'h3333, 64'h2222, 64'h1111}),
      .rsp(rsp));
   rft_pipe_model pipe (.pclk(pclk), .req(req), .rsp(rsp));
   // -------------------------
   // Clock, hang guard, tasks
   // -------------------------
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string n, input logic [81:0] s, input logic [81:0] x);
      checks_done++;
      if (s !== x) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   // APB transfer, held until pready seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rq(input rft_op_t o, input rft_kind_t kd, input logic [6:0] i,
                     input logic [63:0] g, input logic [81:0] f, input logic [23:0] im,
                     input logic nt);
      pipe.issue(o, kd, i, g, nt, f, im, 3'h5);
      r = pipe.seen;
      nops++;
   endtask : rq
   // -------------------------
   // Test sequence
   // -------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `RFT_OFF_PSR, '0);
      chk("psr_rst", q, '0);
      chk("idle", {pready, pslverr, rsp.valid}, 3'b100);
      apb(1'b0, `RFT_OFF_PRED_LO, '0);
      chk("pred_rst", q, 32'h1);
      apb(1'b0, 12'h020, '0);
      chk("unmapped", {q, e}, {32'h0, 1'b1});
      $display("test reset done");
      rq(OP_PR_MASK, KIND_PR, 0, 64'h800a, '0, 24'h008007, 0);
      rq(OP_MOV_TO_GR, KIND_PR, 0, '0, '0, '0, 0);
      chk("pred_mask", r.gr_val, 64'h8003);
      rq(OP_PR_MASK, KIND_PR, 0, '1, '0, 24'h010000, 0);
      apb(1'b0, `RFT_OFF_PRED_HI, '0);
      chk("pred_hi", q, 32'hffff_ffff);
      apb(1'b0, `RFT_OFF_PRED_LO, '0);
      chk("pred_lo", q, 32'hffff_8003);
      rq(OP_PR_ROT, KIND_PR, 0, 64'h1234_5678_9abc_ffff, '0, '0, 0);
      rq(OP_MOV_TO_GR, KIND_PR, 0, '0, '0, '0, 0);
      chk("pred_rot", r.gr_val, 64'h1234_5678_9abc_8003);
      $display("test predicates done");
      rq(OP_SETF_SIG, KIND_BR, 0, 64'h0123_4567_89ab_cdef, '0, '0, 0);
      chk("setf_sig", r.fr_val, {1'b0, `RFT_INT_EXP, 64'h0123_4567_89ab_cdef});
      chk("setf_we", {r.valid, r.fr_we, r.gr_we}, 3'b110);
      rq(OP_GETF_SIG, KIND_BR, 0, '0, {1'b1, 17'h1_2345, 64'hfedc_ba98_7654_3210}, '0, 0);
      chk("getf_sig", r.gr_val, 64'hfedc_ba98_7654_3210);
      rq(OP_GETF_EXP, KIND_BR, 0, '0, {1'b1, 17'h1_2345, 64'hfedc_ba98_7654_3210}, '0, 0);
      chk("getf_exp", r.gr_val, 64'h3_2345);
      rq(OP_SETF_EXP, KIND_BR, 0, 64'h2_0abc, '0, '0, 0);
      chk("setf_exp", r.fr_val, {1'b1, 17'h0_0abc, `RFT_SIG_INT});
      rq(OP_SETF_S, KIND_BR, 0, 64'h3f80_0000, '0, '0, 0);
      chk("setf_s", r.fr_val, ONE);
      rq(OP_GETF_D, KIND_BR, 0, '0, ONE, '0, 0);
      chk("getf_d", r.gr_val, 64'h3ff0_0000_0000_0000);
      rq(OP_SETF_D, KIND_BR, 0, 64'hc000_0000_0000_0000, '0, '0, 0);
      chk("setf_d", r.fr_val, {1'b1, 17'h1_0000, `RFT_SIG_INT});
      rq(OP_GETF_S, KIND_BR, 0, '0, {1'b1, 17'h1_0000, `RFT_SIG_INT}, '0, 0);
      chk("getf_s", r.gr_val, 64'hc000_0000);
      rq(OP_SETF_SIG, KIND_BR, 0, 64'h77, '0, '0, 1);
      chk("nat_to_fr", r.fr_val, {1'b0, `RFT_NATVAL_EXP, 64'h0});
      rq(OP_GETF_SIG, KIND_BR, 0, '0, {1'b0, `RFT_NATVAL_EXP, 64'h0}, '0, 0);
      chk("nat_to_gr", {r.gr_nat, r.gr_val}, {1'b1, 64'h0});
      $display("test float done");
      for (int j = 0; j < 2; j++) begin
         k = j ? KIND_AR : KIND_BR;
         rq(OP_MOV_FROM_GR, k, 7, 64'hbeef_0000 + j, '0, '0, 0);
         if (j == 0) chk("hint", {r.hint_vld, r.hint}, 4'hd);
         rq(OP_MOV_TO_GR, k, 7, '0, '0, '0, 0);
         chk("copy_back", r.gr_val, 64'hbeef_0000 + j);
         rq(OP_MOV_FROM_GR, k, 8, 64'h1, '0, '0, 0);
         chk("idx_range", r.fault, 1'b1);
      end
      $display("test branch and application done");
      apb(1'b1, `RFT_OFF_PSR, 32'h0000_1200);
      rq(OP_MOV_FROM_GR, KIND_UM, 0, 64'h2a, '0, '0, 0);
      apb(1'b0, `RFT_OFF_PSR, '0);
      chk("um_in_psr", q, 32'h0000_122a);
      rq(OP_UM_SET, KIND_UM, 0, '0, '0, 24'h01, 0);
      rq(OP_UM_CLR, KIND_UM, 0, '0, '0, 24'h0a, 0);
      rq(OP_MOV_TO_GR, KIND_UM, 0, '0, '0, '0, 0);
      chk("um_read", r.gr_val, 64'h21);
      apb(1'b0, `RFT_OFF_PSR, '0);
      chk("um_psr", q, 32'h0000_1221);
      $display("test user mask done");
      rq(OP_MOV_TO_GR, KIND_PMD, 2, '0, '0, '0, 0);
      chk("pmd_off", r.gr_val, '0);
      apb(1'b1, `RFT_OFF_CTRL, 32'h1);
      rq(OP_MOV_TO_GR, KIND_PMD, 2, '0, '0, '0, 0);
      chk("pmd_on", r.gr_val, 64'h3333);
      rq(OP_MOV_TO_GR, KIND_CPUID, 4, '0, '0, '0, 0);
      chk("cpuid", r.gr_val, 64'h5);
      rq(OP_MOV_TO_GR, KIND_IP, 0, '0, '0, '0, 0);
      chk("ip", r.gr_val, ip);
      foreach (rk[j]) begin
         rq(j < 4 ? OP_MOV_FROM_GR : OP_NONE, rk[j], 0, 64'h1, '0, '0, 0);
         chk("refused", {r.valid, r.fault, r.gr_we, r.fr_we}, 4'b1100);
      end
      apb(1'b0, `RFT_OFF_PRED_LO, '0);
      chk("pred_kept", q, 32'h9abc_8003);
      apb(1'b0, `RFT_OFF_OPCNT, '0);
      chk("opcount", q, nops);
      $display("test read-only files done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
